// File: verilog/aops_pkg.sv
// Constants and types shared by the converter output pipeline and its FIFO.
// Assumes a SystemVerilog-2012 tool flow; no clocks or resets live here.
package aops_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and depths.
    localparam int unsigned AOPS_DATA_W = 10;
    localparam int unsigned AOPS_FIFO_DEPTH = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts.
    localparam int unsigned AOPS_PIPE_LATENCY = 4;
    localparam int unsigned AOPS_LINK_SYNC_STAGES = 2;
    localparam int unsigned AOPS_PRIME_CYCLES = AOPS_PIPE_LATENCY + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [AOPS_DATA_W-1:0] AOPS_DATA_RST = 10'h000;
    localparam logic AOPS_STROBE_RST = 1'b0;
    localparam logic AOPS_READY_RST = 1'b0;
    localparam logic [2:0] AOPS_PRIME_RST = 3'h0;
    localparam logic [AOPS_LINK_SYNC_STAGES-1:0] AOPS_LINK_RST_ON = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe start-up state.
    typedef enum logic [0:0] {
        AOPS_ST_HELD = 1'b0,
        AOPS_ST_RUN  = 1'b1
    } aops_strobe_state_t;

endpackage : aops_pkg

// File: verilog/aops_stream_if.sv
// Word stream between the converter pipeline and the clock-crossing FIFO.
// Assumes the write side runs on the encoding clock and the read side on the link clock.
`timescale 1ns/100ps
`default_nettype none

interface aops_stream_if #(
    parameter int unsigned WIDTH = 10
);
    logic wr_valid;
    logic wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [WIDTH-1:0] rd_data;

    modport source (
        output wr_valid,
        output wr_data,
        input wr_ready,
        input rd_valid,
        input rd_data,
        output rd_ready
    );

    modport fifo (
        input wr_valid,
        input wr_data,
        output wr_ready,
        output rd_valid,
        output rd_data,
        input rd_ready
    );
endinterface : aops_stream_if

`default_nettype wire

// File: verilog/aops_async_fifo.sv
// Dual-clock FIFO with gray-coded pointers and a registered read stage.
// Assumes each reset is asserted asynchronously and released in its own clock domain.
`timescale 1ns/100ps
`default_nettype none

module aops_async_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 8
) (
    // Write domain.
    input wire logic wr_clk_i,
    input wire logic wr_rst_i,
    // Read domain.
    input wire logic rd_clk_i,
    input wire logic rd_rst_i,
    // Stream.
    aops_stream_if.fifo port_if
);
    localparam int unsigned AW = $clog2(DEPTH);

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction : bin2gray

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wbin_reg, wbin_next, wgray_reg, wgray_next;
    logic [AW:0] rbin_reg, rbin_next, rgray_reg, rgray_next;
    logic [AW:0] rq1_reg, rq2_reg, wq1_reg, wq2_reg;
    logic out_valid_reg, out_valid_next;
    logic [WIDTH-1:0] out_data_reg, out_data_next;
    logic full, empty, push, load;

    ////////////////////////////////////////////////////////////////////////////
    // Write side.
    always_comb begin
        full = (wgray_reg == {~rq2_reg[AW:AW-1], rq2_reg[AW-2:0]});
        push = port_if.wr_valid && !full;
        wbin_next = push ? wbin_reg + 1'b1 : wbin_reg;
        wgray_next = bin2gray(wbin_next);
    end

    assign port_if.wr_ready = !full;

    always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
        if (wr_rst_i) begin
            wbin_reg <= '0;
            wgray_reg <= '0;
            rq1_reg <= '0;
            rq2_reg <= '0;
        end else begin
            wbin_reg <= wbin_next;
            wgray_reg <= wgray_next;
            rq1_reg <= rgray_reg;
            rq2_reg <= rq1_reg;
        end
    end

    always_ff @(posedge wr_clk_i) begin
        if (push) begin
            mem[wbin_reg[AW-1:0]] <= port_if.wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read side.
    always_comb begin
        empty = (rgray_reg == wq2_reg);
        load = !empty && (!out_valid_reg || port_if.rd_ready);
        rbin_next = load ? rbin_reg + 1'b1 : rbin_reg;
        rgray_next = bin2gray(rbin_next);
        out_data_next = load ? mem[rbin_reg[AW-1:0]] : out_data_reg;
        if (load) begin
            out_valid_next = 1'b1;
        end else if (port_if.rd_ready) begin
            out_valid_next = 1'b0;
        end else begin
            out_valid_next = out_valid_reg;
        end
    end

    always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
        if (rd_rst_i) begin
            rbin_reg <= '0;
            rgray_reg <= '0;
            wq1_reg <= '0;
            wq2_reg <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else begin
            rbin_reg <= rbin_next;
            rgray_reg <= rgray_next;
            wq1_reg <= wgray_reg;
            wq2_reg <= wq1_reg;
            out_valid_reg <= out_valid_next;
            out_data_reg <= out_data_next;
        end
    end

    assign port_if.rd_valid = out_valid_reg;
    assign port_if.rd_data = out_data_reg;

endmodule : aops_async_fifo

`default_nettype wire

// File: verilog/aops_output_pipeline.sv
// Output pipeline and half-rate data strobe of a 10-bit converter, with a link-side FIFO.
// Assumes sample_i comes from the quantizer on the encoding clock and strobe_reset_n_i is a pin.
`timescale 1ns/100ps
`default_nettype none

module aops_output_pipeline
    import aops_pkg::*;
(
    // Encoding clock and system reset.
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Converter side.
    input wire logic strobe_reset_n_i,
    input wire logic [AOPS_DATA_W-1:0] sample_i,
    // Parallel outputs.
    output logic [AOPS_DATA_W-1:0] data_o,
    output logic output_data_strobe_o,
    output logic capture_ready_o,
    // Link side.
    input wire logic link_clk_i,
    input wire logic link_ready_i,
    output logic [AOPS_DATA_W-1:0] link_data_o,
    output logic link_valid_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic [AOPS_DATA_W-1:0] stage_reg [0:AOPS_PIPE_LATENCY-1];
    logic [AOPS_DATA_W-1:0] stage_next [0:AOPS_PIPE_LATENCY-1];
    logic [AOPS_DATA_W-1:0] data_reg, data_next;
    aops_strobe_state_t run_reg, run_next;
    logic strobe_reg, strobe_next;
    logic strobe_clear;
    logic ready_reg, ready_next;
    logic [AOPS_LINK_SYNC_STAGES-1:0] link_rst_reg, link_rst_next;
    logic link_rst;
    logic [2:0] prime_reg;
    logic [2:0] prime_next;
    logic primed;

    aops_stream_if #(.WIDTH(AOPS_DATA_W)) stream_if ();

    ////////////////////////////////////////////////////////////////////////////
    // Sample capture and pipeline.
    always_comb begin
        stage_next[0] = sample_i;
        for (int i = 1; i < AOPS_PIPE_LATENCY; i++) begin
            stage_next[i] = stage_reg[i-1];
        end
        data_next = stage_reg[AOPS_PIPE_LATENCY-1];
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < AOPS_PIPE_LATENCY; i++) begin
                stage_reg[i] <= AOPS_DATA_RST;
            end
            data_reg <= AOPS_DATA_RST;
        end else begin
            for (int i = 0; i < AOPS_PIPE_LATENCY; i++) begin
                stage_reg[i] <= stage_next[i];
            end
            data_reg <= data_next;
        end
    end

    assign data_o = data_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe start-up and toggling.
    assign strobe_clear = sys_rst_i || !strobe_reset_n_i;

    always_comb begin
        case (run_reg)
            AOPS_ST_HELD: run_next = AOPS_ST_RUN;
            AOPS_ST_RUN: run_next = AOPS_ST_RUN;
            default: run_next = AOPS_ST_HELD;
        endcase
    end

    // A rising edge must pass after release before the strobe may move.
    always_ff @(posedge clock_i or posedge strobe_clear) begin
        if (strobe_clear) begin
            run_reg <= AOPS_ST_HELD;
        end else begin
            run_reg <= run_next;
        end
    end

    always_comb begin
        strobe_next = (run_reg == AOPS_ST_RUN) ? ~strobe_reg : strobe_reg;
    end

    always_ff @(negedge clock_i or posedge strobe_clear) begin
        if (strobe_clear) begin
            strobe_reg <= AOPS_STROBE_RST;
        end else begin
            strobe_reg <= strobe_next;
        end
    end

    assign output_data_strobe_o = strobe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Pipeline fill after system reset, so that reset words never reach the link.
    always_comb begin
        if (prime_reg == 3'(AOPS_PRIME_CYCLES)) begin
            prime_next = prime_reg;
        end else begin
            prime_next = prime_reg + 3'h1;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prime_reg <= AOPS_PRIME_RST;
        end else begin
            prime_reg <= prime_next;
        end
    end

    assign primed = (prime_reg == 3'(AOPS_PRIME_CYCLES));

    ////////////////////////////////////////////////////////////////////////////
    // FIFO feed on the encoding clock.
    assign stream_if.wr_valid = (run_reg == AOPS_ST_RUN) && primed;
    assign stream_if.wr_data = data_reg;

    always_comb begin
        ready_next = stream_if.wr_ready;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ready_reg <= AOPS_READY_RST;
        end else begin
            ready_reg <= ready_next;
        end
    end

    assign capture_ready_o = ready_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Link-domain reset release.
    always_comb begin
        link_rst_next = {link_rst_reg[AOPS_LINK_SYNC_STAGES-2:0], 1'b0};
    end

    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link_rst_reg <= AOPS_LINK_RST_ON;
        end else begin
            link_rst_reg <= link_rst_next;
        end
    end

    assign link_rst = link_rst_reg[AOPS_LINK_SYNC_STAGES-1];

    ////////////////////////////////////////////////////////////////////////////
    // Clock-crossing FIFO.
    aops_async_fifo #(
        .WIDTH(AOPS_DATA_W),
        .DEPTH(AOPS_FIFO_DEPTH)
    ) u_fifo (
        .wr_clk_i(clock_i),
        .wr_rst_i(sys_rst_i),
        .rd_clk_i(link_clk_i),
        .rd_rst_i(link_rst),
        .port_if(stream_if.fifo)
    );

    assign stream_if.rd_ready = link_ready_i;
    assign link_data_o = stream_if.rd_data;
    assign link_valid_o = stream_if.rd_valid;

endmodule : aops_output_pipeline

`default_nettype wire

// File: dv/aops_output_pipeline_monitor.sv
// Port-level checks on the converter output pipeline.
// Assumes aops_pkg is compiled first; attached by the bind at the foot.
`timescale 1ns/100ps
`default_nettype none

module aops_output_pipeline_monitor
    import aops_pkg::*;
(
    // Watched ports.
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic strobe_reset_n_i,
    input wire logic [AOPS_DATA_W-1:0] sample_i,
    input wire logic [AOPS_DATA_W-1:0] data_o,
    input wire logic output_data_strobe_o,
    input wire logic capture_ready_o,
    input wire logic link_clk_i,
    input wire logic link_ready_i,
    input wire logic [AOPS_DATA_W-1:0] link_data_o,
    input wire logic link_valid_o
);
    logic [2:0] run_reg, run_next, age_reg, age_next;
    logic [AOPS_DATA_W-1:0] half_reg, half_next;
    logic pos_reg, pos_next;
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    always_comb begin
        run_next = run_reg + {2'h0, run_reg != 3'h7};
        age_next = age_reg + {2'h0, age_reg != 3'h7};
        half_next = data_o;
        pos_next = output_data_strobe_o;
    end
    always_ff @(posedge clock_i or posedge sys_rst_i or negedge strobe_reset_n_i) begin
        if (sys_rst_i || !strobe_reset_n_i) run_reg <= 3'h0;
        else run_reg <= run_next;
    end
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            age_reg <= 3'h0;
            pos_reg <= AOPS_STROBE_RST;
        end else begin
            age_reg <= age_next;
            pos_reg <= pos_next;
        end
    end
    always_ff @(negedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) half_reg <= AOPS_DATA_RST;
        else half_reg <= half_next;
    end

    ////////////////////////////////////////////////////////////
    a_data_latency: assert property (age_reg >= 3'h5 |-> data_o == $past(sample_i, 5))
        else $error("data word latency wrong");
    a_strobe_held: assert property (!strobe_reset_n_i |-> !output_data_strobe_o)
        else $error("strobe not held low");
    a_strobe_unarmed: assert property (run_reg == 3'h0 |-> !output_data_strobe_o)
        else $error("strobe high before arming");
    a_first_rise: assert property (run_reg == 3'h1 |-> output_data_strobe_o)
        else $error("first strobe rise misplaced");
    a_strobe_toggle: assert property (run_reg >= 3'h2 |-> $changed(output_data_strobe_o))
        else $error("strobe missed a toggle");
    a_strobe_on_fall: assert property (@(negedge clock_i) run_reg != 3'h0 |-> output_data_strobe_o == pos_reg)
        else $error("strobe moved off the falling edge");
    a_data_whole_period: assert property (data_o == half_reg)
        else $error("data changed mid period");
    a_third_rise_word: assert property (run_reg == 3'h5 |-> output_data_strobe_o && data_o == $past(sample_i, 5))
        else $error("first word not at third rise");
    c_restart: cover property (run_reg == 3'h5);
    c_full: cover property (!capture_ready_o);
    c_link_take: cover property (@(posedge link_clk_i) link_valid_o && link_ready_i);
endmodule : aops_output_pipeline_monitor

bind aops_output_pipeline aops_output_pipeline_monitor u_aops_output_pipeline_monitor (.clock_i,
    .sys_rst_i, .strobe_reset_n_i, .sample_i, .data_o, .output_data_strobe_o, .capture_ready_o,
    .link_clk_i, .link_ready_i, .link_data_o, .link_valid_o);

`default_nettype wire

// File: dv/aops_link_receiver.sv
// Behavioural acquisition logic taking words from the link side.
// Assumes it shares the link clock and the system reset with the device.
`timescale 1ns/100ps
`default_nettype none

module aops_link_receiver
    import aops_pkg::*;
(
    // Link clock and reset.
    input wire logic link_clk_i,
    input wire logic sys_rst_i,
    // Stream from the device.
    input wire logic link_valid_i,
    input wire logic [AOPS_DATA_W-1:0] link_data_i,
    input wire logic stall_i,
    output logic link_ready_o,
    // Words taken.
    output logic got_o,
    output logic [AOPS_DATA_W-1:0] word_o
);
    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link_ready_o <= 1'b0;
            got_o <= 1'b0;
            word_o <= '0;
        end else begin
            link_ready_o <= !stall_i && ($urandom % 3 != 0);
            got_o <= link_valid_i && link_ready_o;
            word_o <= link_data_i;
        end
    end
endmodule : aops_link_receiver

`default_nettype wire

// File: dv/aops_output_pipeline_test.sv
// Self-checking bench for the converter output pipeline.
// Assumes the design, the monitor and the link receiver are compiled first.
`timescale 1ns/100ps
`default_nettype none

module aops_output_pipeline_test;
    import aops_pkg::*;
    logic clock_i = 1'b0, link_clk_i = 1'b0, sys_rst_i = 1'b1, strobe_reset_n_i = 1'b0;
    logic stall = 1'b0;
    logic [AOPS_DATA_W-1:0] sample_i = '0, next_word = '0;
    logic [AOPS_DATA_W-1:0] data_o, link_data, word, exp_q[$];
    logic strobe, capture_ready, link_ready, link_valid, got;
    int n_fail = 0, cmp_count = 0;

    aops_output_pipeline u_aops_output_pipeline (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .strobe_reset_n_i(strobe_reset_n_i), .sample_i(sample_i), .data_o(data_o),
        .output_data_strobe_o(strobe), .capture_ready_o(capture_ready), .link_clk_i(link_clk_i),
        .link_ready_i(link_ready), .link_data_o(link_data), .link_valid_o(link_valid));
    aops_link_receiver u_aops_link_receiver (.link_clk_i(link_clk_i), .sys_rst_i(sys_rst_i),
        .link_valid_i(link_valid), .link_data_i(link_data), .stall_i(stall),
        .link_ready_o(link_ready), .got_o(got), .word_o(word));

    initial forever #2.5 clock_i = ~clock_i;
    initial begin
        #7.3;
        forever #15 link_clk_i = ~link_clk_i;
    end

    ////////////////////////////////////////////////////////////
    task chk(input bit ok, input string what);
        cmp_count++;
        if (!ok) begin
            n_fail++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask : chk

    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task restart(input bit hi);
        if (hi) @(posedge clock_i);
        else @(negedge clock_i);
        #1 strobe_reset_n_i = 1'b1;
        @(negedge clock_i);
        #1 chk(strobe === !hi, "first strobe level wrong");
        @(negedge clock_i);
        #1 chk(strobe === hi, "second strobe level wrong");
    endtask : restart

    task hold_off(input int n);
        @(posedge clock_i);
        #1 strobe_reset_n_i = 1'b0;
        #0.5 chk(strobe === 1'b0, "strobe not cleared at once");
        repeat (n) @(negedge clock_i);
        #1 chk(strobe === 1'b0, "strobe not held");
    endtask : hold_off

    task sys_reset;
        sys_rst_i <= 1'b1;
        #1 chk(data_o === AOPS_DATA_RST && strobe === 1'b0 && link_valid === 1'b0, "reset values");
        repeat (3) @(posedge link_clk_i);
        @(negedge clock_i);
        sys_rst_i <= 1'b0;
    endtask : sys_reset

    always @(negedge clock_i) begin
        sample_i <= next_word;
        exp_q.push_back(next_word);
        next_word <= next_word + 10'h001;
    end

    always @(posedge link_clk_i) begin
        if (got === 1'b1) begin
            while (exp_q.size() > 0 && exp_q[0] !== word) void'(exp_q.pop_front());
            chk(exp_q.size() > 0, "link word out of order");
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end

    initial begin
        #20000;
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        give_verdict();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hca20));
        next_word = 10'($urandom);
        repeat (3) @(posedge link_clk_i);
        @(negedge clock_i);
        sys_rst_i <= 1'b0;
        restart(1'b0);
        repeat (10) @(negedge clock_i);
        $display("test restart_clock_low done");
        hold_off(4);
        restart(1'b1);
        $display("test restart_clock_high done");
        stall = 1'b1;
        repeat (30) @(negedge clock_i);
        chk(capture_ready === 1'b0 && link_valid === 1'b1, "fifo did not fill");
        $display("test fill done");
        stall = 1'b0;
        hold_off(2);
        for (int i = 0; i < 100 && link_valid !== 1'b0; i++) @(posedge link_clk_i);
        @(negedge clock_i);
        chk(link_valid === 1'b0 && capture_ready === 1'b1, "fifo did not drain");
        $display("test drain done");
        restart(1'b0);
        repeat (40) begin
            repeat (8) @(negedge clock_i);
            stall = 1'($urandom % 2);
        end
        stall = 1'b0;
        $display("test random_stall done");
        @(negedge clock_i);
        sys_reset();
        repeat (60) @(negedge clock_i);
        $display("test second_reset done");
        give_verdict();
    end
endmodule : aops_output_pipeline_test

`default_nettype wire
